/* sr4jk_top.sv */
// four-stage shift register with j / inverted-k first stage and snapshot stream
//
// What this block does
// - clear low forces all stages low and complemented last output high.
// - select low at a clock rise loads the four parallel inputs at once.
// - apart from clear, stages and register outputs change only on a rising shift clock edge.
// - during parallel load the serial j and inverted-k inputs are ignored.
// - select high at a clock rise performs exactly one shift step.
// - each shift moves every stage one place toward the last stage.
// - first stage: both low gives low, both high gives high, j low k_n high holds.
// - first stage acts as j-k, d or t flip-flop; tying j to k_n gives d.
// - complemented last output always equals the inverse of the last stage.
`timescale 1ns/1ns
module sr4jk_top
   import sr4jk_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   input  wire logic              i_shift_clk,
   input  wire logic              i_async_zeroing_n,
   input  wire logic              i_shift_load_select,
   input  wire logic              i_serial_j,
   input  wire logic              i_serial_k_n,
   input  wire logic [STAGES-1:0] i_parallel_data,
   input  wire logic              i_snap_ready,
   output logic [STAGES-1:0]      o_stages,
   output logic                   o_stage_first_out,
   output logic                   o_stage_last_out,
   output logic                   o_stage_last_out_n,
   output logic                   o_snap_valid,
   output logic [SNAP_W-1:0]      o_snap_data,
   output logic                   o_snap_space
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [PIN_W-1:0]  pin_raw;
   logic [PIN_W-1:0]  sync1_ff, nxt_sync1;
   logic [PIN_W-1:0]  sync2_ff, nxt_sync2;
   logic [1:0]        prev_ff, nxt_prev;

   // decoded views of the second sync stage
   logic              clk_s;
   logic              zero_n_s;
   logic              sel_s;
   logic              j_s;
   logic              kn_s;
   logic [STAGES-1:0] par_s;
   logic              edge_rise;
   logic              clear_entry;

   assign pin_raw = {i_shift_clk, i_async_zeroing_n, i_shift_load_select,
                     i_serial_j, i_serial_k_n, i_parallel_data};

   assign clk_s    = sync2_ff[PIN_CLK];
   assign zero_n_s = sync2_ff[PIN_ZN];
   assign sel_s    = sync2_ff[PIN_SEL];
   assign j_s      = sync2_ff[PIN_J];
   assign kn_s     = sync2_ff[PIN_KN];
   assign par_s    = sync2_ff[PIN_PAR_LSB +: STAGES];

   // rising shift clock and falling clear, seen on the second stage only
   assign edge_rise   = clk_s & ~prev_ff[1];
   assign clear_entry = ~zero_n_s & prev_ff[0];

   // two-stage chain, first stage feeds only the second
   always_comb begin
      nxt_sync1 = pin_raw;
      nxt_sync2 = sync1_ff;
      nxt_prev  = {clk_s, zero_n_s};
   end

   // sync and edge history registers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sync1_ff <= PIN_RST;
         sync2_ff <= PIN_RST;
         prev_ff  <= PREV_RST;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         prev_ff  <= nxt_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register core

   logic [STAGES-1:0] stages_ff, nxt_stages;
   logic              last_n_ff, nxt_last_n;
   logic              first_new;
   logic              push_ff, nxt_push;
   logic [SNAP_W-1:0] push_data_ff, nxt_push_data;
   sr4jk_cause_t      cause;

   // first stage value from the serial pair during a shift
   // j-k, d or t entry
   always_comb begin
      unique case ({j_s, kn_s})
         2'b01:   first_new = stages_ff[0];
         2'b00:   first_new = 1'b0;
         2'b11:   first_new = 1'b1;
         2'b10:   first_new = ~stages_ff[0];
      endcase
   end

   // next contents: clear overrides, else act on the edge only
   always_comb begin
      nxt_stages = stages_ff;
      nxt_push   = 1'b0;
      cause      = SR4JK_CAUSE_CLEAR;
      if (!zero_n_s) begin
         nxt_stages = STAGES_RST;
         nxt_push   = clear_entry;
      // update only on a rising edge
      end else if (edge_rise) begin
         nxt_push = 1'b1;
         if (sel_s == SEL_LOAD) begin
            nxt_stages = par_s;
            cause      = SR4JK_CAUSE_LOAD;
         end else begin
            nxt_stages = {stages_ff[STAGES-2:0], first_new};
            cause      = SR4JK_CAUSE_SHIFT;
         end
      end
      nxt_last_n    = ~nxt_stages[STAGES-1];
      nxt_push_data = {cause, nxt_stages};
   end

   // core and snapshot push registers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         stages_ff    <= STAGES_RST;
         last_n_ff    <= LAST_N_RST;
         push_ff      <= 1'b0;
         push_data_ff <= '0;
      end else begin
         stages_ff    <= nxt_stages;
         last_n_ff    <= nxt_last_n;
         push_ff      <= nxt_push;
         push_data_ff <= nxt_push_data;
      end
   end

   // register outputs
   assign o_stages           = stages_ff;
   assign o_stage_first_out  = stages_ff[0];
   assign o_stage_last_out   = stages_ff[STAGES-1];
   assign o_stage_last_out_n = last_n_ff;

   ////////////////////////////////////////////////////////////////////////////
   // snapshot fifo

   sr4jk_snap_if #(.W(SNAP_W)) snap_if ();

   // a snapshot offered when the fifo is full is not stored
   assign snap_if.wr_valid = push_ff;
   assign snap_if.wr_data  = push_data_ff;
   assign snap_if.rd_ready = i_snap_ready;

   sr4jk_fifo #(
      .W     (SNAP_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .port_if (snap_if)
   );

   // fifo flags and head come from fifo flip-flops
   assign o_snap_valid = snap_if.rd_valid;
   assign o_snap_data  = snap_if.rd_data;
   assign o_snap_space = snap_if.wr_ready;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   clear_forces_a: assert property (
      !zero_n_s |=> (stages_ff == STAGES_RST) && last_n_ff)
      else $error("clear did not force stages low");

   load_copies_a: assert property (
      (zero_n_s && edge_rise && sel_s == SEL_LOAD) |=> stages_ff == $past(par_s))
      else $error("load did not copy parallel inputs");

   no_edge_hold_a: assert property (
      (zero_n_s && !edge_rise) |=> $stable(stages_ff))
      else $error("stages changed without a clock edge");

   load_serial_a: assert property (
      (zero_n_s && edge_rise && sel_s == SEL_LOAD && j_s && !kn_s)
      |=> stages_ff[0] == $past(par_s[0]))
      else $error("serial inputs disturbed a load");

   shift_moves_a: assert property (
      (zero_n_s && edge_rise && sel_s == SEL_SHIFT)
      |=> stages_ff[STAGES-1:1] == $past(stages_ff[STAGES-2:0]))
      else $error("shift did not move stages by one");

   // tied serial pair behaves as d entry
   d_entry_a: assert property (
      (zero_n_s && edge_rise && sel_s == SEL_SHIFT && j_s == kn_s)
      |=> stages_ff[0] == $past(j_s))
      else $error("d entry gave wrong first stage");

   // j low k_n high holds first stage
   first_hold_a: assert property (
      (zero_n_s && edge_rise && sel_s == SEL_SHIFT && !j_s && kn_s)
      |=> stages_ff[0] == $past(stages_ff[0]))
      else $error("first stage did not hold");

   first_toggle_a: assert property (
      (zero_n_s && edge_rise && sel_s == SEL_SHIFT && j_s && !kn_s)
      |=> stages_ff[0] != $past(stages_ff[0]))
      else $error("first stage did not toggle");

   comp_output_a: assert property (
      o_stage_last_out_n == ~o_stage_last_out)
      else $error("complemented last output wrong");

   // one edge gives a single snapshot push
   one_step_a: assert property (
      (zero_n_s && edge_rise) |=> push_ff ##1 !push_ff)
      else $error("shift edge did not give exactly one step");

endmodule : sr4jk_top

/* sr4jk_pkg.sv */
// constants and types shared by the four-stage shift register files
package sr4jk_pkg;

   // register geometry
   localparam int STAGES     = 4;
   localparam int SNAP_W     = STAGES + 2;
   localparam int FIFO_DEPTH = 16;

   // clock rate of the block
   localparam int CLOCK_PERIOD_NS = 40;

   // positions of the pins inside the sampled pin vector
   localparam int PIN_PAR_LSB = 0;
   localparam int PIN_KN      = 4;
   localparam int PIN_J       = 5;
   localparam int PIN_SEL     = 6;
   localparam int PIN_ZN      = 7;
   localparam int PIN_CLK     = 8;
   localparam int PIN_W       = 9;

   // values after reset
   localparam logic [PIN_W-1:0]  PIN_RST    = 9'h000;
   localparam logic [STAGES-1:0] STAGES_RST = 4'h0;
   localparam logic              LAST_N_RST = 1'b1;
   localparam logic [1:0]        PREV_RST   = 2'h0;

   // select levels at a rising shift clock edge
   localparam logic SEL_LOAD  = 1'b0;
   localparam logic SEL_SHIFT = 1'b1;

   // what caused a snapshot word
   typedef enum logic [1:0] {
      SR4JK_CAUSE_CLEAR,
      SR4JK_CAUSE_LOAD,
      SR4JK_CAUSE_SHIFT
   } sr4jk_cause_t;

endpackage : sr4jk_pkg

/* sr4jk_snap_if.sv */
// snapshot stream between the register core and its fifo
`timescale 1ns/1ns
interface sr4jk_snap_if
   import sr4jk_pkg::*;
#(
   parameter int W = SNAP_W
);
   logic         wr_valid;
   logic [W-1:0] wr_data;
   logic         wr_ready;
   logic         rd_valid;
   logic [W-1:0] rd_data;
   logic         rd_ready;

   modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
   modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : sr4jk_snap_if

/* sr4jk_fifo.sv */
// first-word-fall-through fifo with registered read data and flags
`timescale 1ns/1ns
module sr4jk_fifo
   import sr4jk_pkg::*;
#(
   parameter int W     = SNAP_W,
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic   i_clock,
   input  wire logic   i_rst,
   sr4jk_snap_if.fifo  port_if
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
   logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
   logic [CW-1:0] count_ff, nxt_count;
   logic          not_full_ff, nxt_not_full;
   logic          valid_ff, nxt_valid;
   logic [W-1:0]  data_ff, nxt_data;
   logic          wr_fire;
   logic          rd_fire;

   // flags and head word straight from flip-flops
   assign port_if.wr_ready = not_full_ff;
   assign port_if.rd_valid = valid_ff;
   assign port_if.rd_data  = data_ff;

   // pointer, count and head word bookkeeping
   always_comb begin
      wr_fire      = port_if.wr_valid & not_full_ff;
      rd_fire      = valid_ff & port_if.rd_ready;
      nxt_wr_ptr   = wr_fire ? wr_ptr_ff + AW'(1) : wr_ptr_ff;
      nxt_rd_ptr   = rd_fire ? rd_ptr_ff + AW'(1) : rd_ptr_ff;
      nxt_count    = count_ff + CW'(wr_fire) - CW'(rd_fire);
      nxt_not_full = (nxt_count != FULL_COUNT);
      nxt_valid    = (nxt_count != '0);
      // bypass when the new head is the word written now
      if (wr_fire && (nxt_rd_ptr == wr_ptr_ff)) begin
         nxt_data = port_if.wr_data;
      end else if (nxt_valid) begin
         nxt_data = mem[nxt_rd_ptr];
      end else begin
         // empty: keep the old head, unwritten words would read unknown
         nxt_data = data_ff;
      end
   end

   // storage array, written only
   always_ff @(posedge i_clock) begin
      if (wr_fire) begin
         mem[wr_ptr_ff] <= port_if.wr_data;
      end
   end

   // state registers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         wr_ptr_ff   <= '0;
         rd_ptr_ff   <= '0;
         count_ff    <= '0;
         not_full_ff <= 1'b1;
         valid_ff    <= 1'b0;
         data_ff     <= '0;
      end else begin
         wr_ptr_ff   <= nxt_wr_ptr;
         rd_ptr_ff   <= nxt_rd_ptr;
         count_ff    <= nxt_count;
         not_full_ff <= nxt_not_full;
         valid_ff    <= nxt_valid;
         data_ff     <= nxt_data;
      end
   end

   full_flag_a: assert property (@(posedge i_clock) disable iff (i_rst)
      not_full_ff == (count_ff != FULL_COUNT))
      else $error("fifo full flag disagrees with count");

   fill_stall_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (!not_full_ff && !rd_fire) |=> (count_ff == FULL_COUNT))
      else $error("fifo count moved while full and stalled");

endmodule : sr4jk_fifo

/* sr4jk_board.sv */
// board logic model driving the register pins of the shift register
`timescale 1ns/1ns
module sr4jk_board
   import sr4jk_pkg::*;
(
   input  wire logic              i_clock,
   output logic                   o_shift_clk,
   output logic                   o_zeroing_n,
   output logic                   o_select,
   output logic                   o_j,
   output logic                   o_k_n,
   output logic [STAGES-1:0]      o_data
);
   // idle pin levels at time zero
   initial begin
      o_shift_clk = 1'b0;
      o_zeroing_n = 1'b1;
      o_select    = SEL_LOAD;
      o_j         = 1'b0;
      o_k_n       = 1'b0;
      o_data      = 4'h0;
   end

   // mode and data pins, set up well before a clock rise
   task automatic setup(input logic s, input logic j, input logic kn, input logic [3:0] d);
      @(posedge i_clock);
      #1;
      o_select = s;
      o_j      = j;
      o_k_n    = kn;
      o_data   = d;
   endtask : setup

   // one clock pulse; after the hold span the pins flip so late sampling shows
   task automatic pulse();
      @(posedge i_clock);
      #1;
      o_shift_clk = 1'b1;
      repeat (3) @(posedge i_clock);
      #1;
      o_shift_clk = 1'b0;
      o_select    = ~o_select;
      o_j         = ~o_j;
      o_k_n       = ~o_k_n;
      o_data      = ~o_data;
      repeat (4) @(posedge i_clock);
   endtask : pulse

   // clear pin level
   task automatic set_clear(input logic v);
      @(posedge i_clock);
      #1;
      o_zeroing_n = v;
   endtask : set_clear
endmodule : sr4jk_board

/* tb_shift_register_4bit_jk_entry.sv */
// self-checking testbench for the four-stage shift register
`timescale 1ns/1ns
module tb_shift_register_4bit_jk_entry
   import sr4jk_pkg::*;
;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              snap_ready = 1'b0;
   logic              hold_rdy = 1'b0;
   logic              shift_clk, zeroing_n, sel, j, kn;
   logic [STAGES-1:0] data, stages, exp = 4'h0;
   logic              first, last, last_n, snap_valid, snap_space;
   logic [SNAP_W-1:0] snap_data;
   logic [SNAP_W-1:0] q[$];
   int                num_errors = 0;
   int                checks = 0;
   int                seed = 59414;

   initial forever #(CLOCK_PERIOD_NS/2) clk = ~clk;

   sr4jk_board u_board (.i_clock(clk), .o_shift_clk(shift_clk), .o_zeroing_n(zeroing_n),
      .o_select(sel), .o_j(j), .o_k_n(kn), .o_data(data));

   sr4jk_top u_dut (.i_clock(clk), .i_rst(rst), .i_shift_clk(shift_clk),
      .i_async_zeroing_n(zeroing_n), .i_shift_load_select(sel), .i_serial_j(j),
      .i_serial_k_n(kn), .i_parallel_data(data), .i_snap_ready(snap_ready),
      .o_stages(stages), .o_stage_first_out(first), .o_stage_last_out(last),
      .o_stage_last_out_n(last_n), .o_snap_valid(snap_valid), .o_snap_data(snap_data),
      .o_snap_space(snap_space));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic miss(input string msg);
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
   endtask : miss

   task automatic cmp_stages();
      checks++;
      if ({stages, first, last, last_n} !== {exp, exp[0], exp[3], ~exp[3]})
         miss($sformatf("stages %h want %h", stages, exp));
   endtask : cmp_stages

   task automatic cmp_snap(input logic [SNAP_W-1:0] got, input logic [SNAP_W-1:0] want);
      checks++;
      if (got !== want) miss($sformatf("snapshot %h want %h", got, want));
   endtask : cmp_snap

   task automatic cmp_flag(input logic got, input logic want);
      checks++;
      if (got !== want) miss($sformatf("flag %b want %b", got, want));
   endtask : cmp_flag

   task automatic final_report();
      $display("counts checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // one register operation with its expected stages and snapshot
   task automatic op(input logic s, input logic jj, input logic kk, input logic [3:0] d,
                     input bit note);
      logic f;
      u_board.setup(s, jj, kk, d);
      repeat (4) @(posedge clk);
      cmp_stages();
      f = (jj & kk) | (jj & ~exp[0]) | (~kk & exp[0] & ~jj) | (~jj & kk & exp[0]);
      if ({jj, kk} == 2'b00) f = 1'b0;
      exp = (s == SEL_LOAD) ? d : {exp[2:0], f};
      if (note) q.push_back({(s == SEL_LOAD) ? SR4JK_CAUSE_LOAD : SR4JK_CAUSE_SHIFT, exp});
      u_board.pulse();
      cmp_stages();
   endtask : op

   task automatic drain();
      int n;
      n = 0;
      while (q.size() != 0 && n < 600) begin
         @(posedge clk);
         n++;
      end
      if (q.size() != 0) miss("snapshots not drained");
   endtask : drain

   ////////////////////////////////////////////////////////////////////////////////
   // consumer ready, random unless held off
   always @(posedge clk) begin
      #1;
      snap_ready <= hold_rdy ? 1'b0 : 1'($random(seed));
   end

   // snapshot watcher
   always @(posedge clk) begin
      if (!rst && snap_valid === 1'b1 && snap_ready === 1'b1) begin
         if (q.size() == 0) miss("unexpected snapshot");
         else cmp_snap(snap_data, q.pop_front());
      end
   end

   initial begin
      #(CLOCK_PERIOD_NS * 20000);
      miss("watchdog expired");
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [3:0] pat[4];
      logic       b;
      pat = '{4'hf, 4'h0, 4'ha, 4'h5};
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      cmp_stages();
      cmp_flag(snap_space, 1'b1);
      $display("test reset done");
      // loads with serial pins driven to every combination
      for (int i = 0; i < 8; i++)
         op(SEL_LOAD, 1'(i), 1'(i >> 1), (i < 4) ? pat[i] : 4'($random(seed)), 1);
      $display("test load done");
      // every serial pin combination in shift mode
      for (int m = 0; m < 4; m++)
         repeat (3) op(SEL_SHIFT, 1'(m >> 1), 1'(m), 4'($random(seed)), 1);
      // tied pins give d-type entry
      repeat (6) begin
         b = 1'($random(seed));
         op(SEL_SHIFT, b, b, 4'h0, 1);
      end
      $display("test shift done");
      op(SEL_LOAD, 1'b1, 1'b0, 4'hf, 1);
      exp = 4'h0;
      q.push_back({SR4JK_CAUSE_CLEAR, 4'h0});
      u_board.set_clear(1'b0);
      repeat (4) @(posedge clk);
      cmp_stages();
      u_board.setup(SEL_LOAD, 1'b1, 1'b1, 4'hf);
      u_board.pulse();
      cmp_stages();
      u_board.set_clear(1'b1);
      repeat (4) @(posedge clk);
      op(SEL_SHIFT, 1'b1, 1'b1, 4'h0, 1);
      $display("test clear done");
      // fill the snapshot buffer with the consumer stalled
      drain();
      hold_rdy = 1'b1;
      for (int i = 0; i < FIFO_DEPTH + 1; i++)
         op(SEL_SHIFT, 1'($random(seed)), 1'($random(seed)), 4'h0, i < FIFO_DEPTH);
      cmp_flag(snap_space, 1'b0);
      cmp_flag(snap_valid, 1'b1);
      hold_rdy = 1'b0;
      drain();
      repeat (20) @(posedge clk);
      cmp_flag(snap_valid, 1'b0);
      cmp_flag(snap_space, 1'b1);
      $display("test buffer done");
      final_report();
   end
endmodule : tb_shift_register_4bit_jk_entry
